//--- verilog/ee_guard_map.svh
`ifndef EE_GUARD_MAP_SVH
`define EE_GUARD_MAP_SVH

// Array geometry
`define EE_ADDR_W 9
`define EE_DEPTH 512
`define EE_DATA_W 8
`define EE_UPPER_BIT 8

// Page buffer geometry
`define PAGE_BYTES 16
`define PAGE_IDX_W 4

// Select byte field positions
`define SEL_RW_BIT 0
`define SEL_ADDR_MSB_BIT 1
`define SEL_STRAP_LO_BIT 2
`define SEL_STRAP_HI_BIT 3
`define SEL_TYPE_MSB 7
`define SEL_TYPE_LSB 4

// Bit counter positions on the link
`define LAST_DATA_CNT 4'h7
`define ACK_SLOT_CNT 4'h8

// Reset values
`define PTR_RST 9'h000
`define MASK_RST 16'h0000
`define BYTE_RST 8'hFF

// Timing
`define REF_CLK_PERIOD_NS 25
`define PROG_TIME_NS 5000000
`define PROG_CYCLES ((`PROG_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

//--- verilog/ee_guard_pkg.sv
package ee_guard_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_WAIT,
    ST_PROG
  } ctrl_state_e;

endpackage

//--- verilog/eeprom_cell_array.sv
`timescale 1ns/1ps
`default_nettype none

module eeprom_cell_array #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] cells [2**AW];

  // No reset on the cells: contents survive a controller reset
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      cells[waddr_i] <= wdata_i;
    end
    rdata_o <= cells[raddr_i];
  end

endmodule // eeprom_cell_array

`default_nettype wire

//--- verilog/i2c_bit_engine.sv
`timescale 1ns/1ps
`default_nettype none

`include "ee_guard_map.svh"

module i2c_bit_engine (
  // Link clock and resets
  input wire logic scl_i,
  input wire logic rst_i,
  input wire logic frame_rst_i,
  // Serial data in
  input wire logic sda_i,
  // Controls from the reference domain
  input wire logic ack_drive_i,
  input wire logic tx_mode_i,
  input wire logic [7:0] tx_byte_i,
  // Results to the reference domain
  output logic [7:0] rx_byte_o,
  output logic byte_tgl_o,
  output logic mack_tgl_o,
  output logic mack_o,
  // Open-drain pull enable
  output logic sda_oe_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic mack_r;
  logic mack_nxt;
  logic byte_tgl_r;
  logic byte_tgl_nxt;
  logic mack_tgl_r;
  logic mack_tgl_nxt;
  logic oe_r;
  logic oe_nxt;

  // Bits are taken on the rising serial clock edge
  always_comb begin
    cnt_nxt = cnt_r;
    rx_nxt = rx_r;
    mack_nxt = mack_r;
    byte_tgl_nxt = byte_tgl_r;
    mack_tgl_nxt = mack_tgl_r;
    if (cnt_r == `ACK_SLOT_CNT) begin
      cnt_nxt = 4'h0;
      mack_nxt = sda_i; // R6
      mack_tgl_nxt = ~mack_tgl_r;
    end else begin
      rx_nxt = {rx_r[6:0], sda_i}; // R8
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == `LAST_DATA_CNT) begin
        byte_tgl_nxt = ~byte_tgl_r;
      end
    end
  end

  // Drive changes only on the falling edge, while the clock is low
  always_comb begin
    oe_nxt = 1'b0;
    if (cnt_r == `ACK_SLOT_CNT) begin
      oe_nxt = ack_drive_i; // R5
    end else if (tx_mode_i) begin
      oe_nxt = ~tx_byte_i[3'h7 - cnt_r[2:0]]; // R9
    end
  end

  always_ff @(posedge scl_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      mack_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
      mack_r <= mack_nxt;
    end
  end

  // Toggles survive frame resets so no false event is seen across
  always_ff @(posedge scl_i or posedge rst_i) begin
    if (rst_i) begin
      byte_tgl_r <= 1'b0;
      mack_tgl_r <= 1'b0;
    end else begin
      byte_tgl_r <= byte_tgl_nxt;
      mack_tgl_r <= mack_tgl_nxt;
    end
  end

  always_ff @(negedge scl_i or posedge frame_rst_i) begin
    if (frame_rst_i) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
    end
  end

  assign rx_byte_o = rx_r;
  assign byte_tgl_o = byte_tgl_r;
  assign mack_tgl_o = mack_tgl_r;
  assign mack_o = mack_r;
  assign sda_oe_o = oe_r;

endmodule // i2c_bit_engine

`default_nettype wire

//--- verilog/i2c_eeprom_slave_upper_guard.sv
`timescale 1ns/1ps
`default_nettype none

`include "ee_guard_map.svh"

//Contract
// R1: The memory holds 512 bytes reached by a 9-bit byte address.
// R2: With the guard input high, no location from 100h to 1FFh is changed.
// R3: A fixed 4-bit type code is compared with the top nibble of each select byte.
// R4: Every transfer opens with Start, a select byte ending in the direction bit, and an ack slot.
// R5: In writes the device pulls data low in the ninth slot after each byte it takes.
// R6: In reads the master pulls data low in the ninth slot after each byte it takes.
// R7: The master ends writes with Stop after an ack, and reads with Stop after a no-ack.
// R8: All bit shifting runs from the master's serial clock.
// R9: The data line is only ever pulled low or released.
// R10: Single bytes and pages of up to 16 bytes are taken before programming.
// R11: Random reads and sequential reads of consecutive bytes are served while acked.
// R12: Select bit 0 is the direction, 1 for read and 0 for write.
// R13: Select is acked only if bits 3 and 2 match the straps; bit 1 is address bit 8.
// R14: A write into the guarded half acks select and address but no data byte.
// R15: A Stop ending a write starts programming and Start is ignored until it ends; the code programs only if at least one data byte was taken.
// R16: After a master no-ack on read data the device releases and waits for Stop or Start.
module i2c_eeprom_slave_upper_guard
  import ee_guard_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE_ID = 4'h6, // Arbitrary value
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  // Reference clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Serial link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps and guard
  input wire logic chip_addr_strap_low_i,
  input wire logic chip_addr_strap_high_i,
  input wire logic upper_half_write_guard_i,
  // Status
  output logic prog_busy_o
);

  // Pin and crossing synchronisers
  logic scl_s1_r;
  logic scl_s2_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_s3_r;
  logic guard_s1_r;
  logic guard_s2_r;
  logic strap_lo_s1_r;
  logic strap_lo_s2_r;
  logic strap_hi_s1_r;
  logic strap_hi_s2_r;
  logic byte_s1_r;
  logic byte_s2_r;
  logic byte_s3_r;
  logic mack_s1_r;
  logic mack_s2_r;
  logic mack_s3_r;

  // Control state
  ctrl_state_e state_r;
  ctrl_state_e state_nxt;
  logic [`EE_ADDR_W-1:0] ptr_r;
  logic [`EE_ADDR_W-1:0] ptr_nxt;
  logic ack_drive_r;
  logic ack_drive_nxt;
  logic tx_mode_r;
  logic tx_mode_nxt;
  logic [7:0] tx_byte_r;
  logic [7:0] tx_byte_nxt;
  logic reload_r;
  logic reload_nxt;
  logic reload_d_r;
  logic reload_d_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [`PAGE_BYTES-1:0] pmask_r;
  logic [`PAGE_BYTES-1:0] pmask_nxt;
  logic [31:0] pcnt_r;
  logic [31:0] pcnt_nxt;
  logic frame_rst_r;
  logic frame_rst_nxt;

  // Page buffer and array ports
  logic [7:0] page_mem [`PAGE_BYTES];
  logic pb_we;
  logic arr_we;
  logic [`PAGE_IDX_W-1:0] prog_idx;
  logic [7:0] rd_data;

  // Link wires
  logic link_rst;
  logic [7:0] rx_byte;
  logic byte_tgl;
  logic mack_tgl;
  logic mack_lvl;

  // Events
  logic start_ev;
  logic stop_ev;
  logic byte_ev;
  logic mack_ev;

  function automatic logic sel_match(input logic [7:0] b, input logic lo, input logic hi);
    sel_match = (b[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == DEVICE_TYPE_ID) // R3
      && (b[`SEL_STRAP_HI_BIT] == hi) && (b[`SEL_STRAP_LO_BIT] == lo); // R13
  endfunction

  function automatic logic write_blocked(input logic [`EE_ADDR_W-1:0] a, input logic g);
    write_blocked = g && a[`EE_UPPER_BIT]; // R2
  endfunction

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
      guard_s1_r <= 1'b0;
      guard_s2_r <= 1'b0;
      strap_lo_s1_r <= 1'b0;
      strap_lo_s2_r <= 1'b0;
      strap_hi_s1_r <= 1'b0;
      strap_hi_s2_r <= 1'b0;
      byte_s1_r <= 1'b0;
      byte_s2_r <= 1'b0;
      byte_s3_r <= 1'b0;
      mack_s1_r <= 1'b0;
      mack_s2_r <= 1'b0;
      mack_s3_r <= 1'b0;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
      guard_s1_r <= upper_half_write_guard_i;
      guard_s2_r <= guard_s1_r;
      strap_lo_s1_r <= chip_addr_strap_low_i;
      strap_lo_s2_r <= strap_lo_s1_r;
      strap_hi_s1_r <= chip_addr_strap_high_i;
      strap_hi_s2_r <= strap_hi_s1_r;
      byte_s1_r <= byte_tgl;
      byte_s2_r <= byte_s1_r;
      byte_s3_r <= byte_s2_r;
      mack_s1_r <= mack_tgl;
      mack_s2_r <= mack_s1_r;
      mack_s3_r <= mack_s2_r;
    end
  end

  // Start and Stop seen while the clock is high; blind while programming
  assign start_ev = scl_s2_r && sda_s3_r && !sda_s2_r && (state_r != ST_PROG); // R15
  assign stop_ev = scl_s2_r && !sda_s3_r && sda_s2_r && (state_r != ST_PROG);
  assign byte_ev = byte_s2_r ^ byte_s3_r;
  assign mack_ev = mack_s2_r ^ mack_s3_r;

  // Link logic reset at each Start and Stop and held in reset through programming
  assign link_rst = rst_i | frame_rst_r;

  // Controller next state
  always_comb begin
    state_nxt = state_r;
    ptr_nxt = ptr_r;
    ack_drive_nxt = ack_drive_r;
    tx_mode_nxt = tx_mode_r;
    tx_byte_nxt = reload_d_r ? rd_data : tx_byte_r;
    reload_nxt = 1'b0;
    reload_d_nxt = reload_r;
    armed_nxt = armed_r;
    pmask_nxt = pmask_r;
    pcnt_nxt = pcnt_r;
    frame_rst_nxt = start_ev || stop_ev || (state_r == ST_PROG);
    pb_we = 1'b0;
    arr_we = 1'b0;
    prog_idx = pcnt_r[`PAGE_IDX_W-1:0];
    if (state_r == ST_PROG) begin
      pcnt_nxt = pcnt_r + 32'h1;
      if (pcnt_r < `PAGE_BYTES) begin
        arr_we = pmask_r[prog_idx]; // R10
      end
      if (pcnt_r >= PROG_CYCLES - 1) begin
        state_nxt = ST_IDLE;
        pmask_nxt = `MASK_RST;
        pcnt_nxt = 32'h0;
      end
    end else if (start_ev) begin
      state_nxt = ST_SEL; // R4
      ack_drive_nxt = 1'b0;
      tx_mode_nxt = 1'b0;
      armed_nxt = 1'b0;
    end else if (stop_ev) begin
      ack_drive_nxt = 1'b0;
      tx_mode_nxt = 1'b0;
      armed_nxt = 1'b0;
      if ((state_r == ST_WDATA) && (pmask_r != `MASK_RST)) begin
        state_nxt = ST_PROG; // R15
        pcnt_nxt = 32'h0;
      end else begin
        state_nxt = ST_IDLE;
      end
    end else if (byte_ev) begin
      case (state_r)
        ST_SEL: begin
          if (sel_match(rx_byte, strap_lo_s2_r, strap_hi_s2_r)) begin
            ack_drive_nxt = 1'b1; // R13
            ptr_nxt = {rx_byte[`SEL_ADDR_MSB_BIT], ptr_r[7:0]}; // R13
            if (rx_byte[`SEL_RW_BIT]) begin
              state_nxt = ST_RDATA; // R12
              tx_mode_nxt = 1'b1;
              reload_nxt = 1'b1;
              armed_nxt = 1'b0;
            end else begin
              state_nxt = ST_ADDR; // R12
            end
          end else begin
            state_nxt = ST_WAIT; // R13
            ack_drive_nxt = 1'b0;
          end
        end
        ST_ADDR: begin
          ptr_nxt = {ptr_r[`EE_UPPER_BIT], rx_byte}; // R1
          pmask_nxt = `MASK_RST;
          ack_drive_nxt = 1'b1; // R14
          state_nxt = ST_WDATA;
        end
        ST_WDATA: begin
          if (write_blocked(ptr_r, guard_s2_r)) begin
            ack_drive_nxt = 1'b0; // R14
          end else begin
            ack_drive_nxt = 1'b1; // R5
            pb_we = 1'b1;
            pmask_nxt[ptr_r[`PAGE_IDX_W-1:0]] = 1'b1; // R10
            // Roll over inside the page, as the page buffer holds one page only
            ptr_nxt = {ptr_r[`EE_ADDR_W-1:`PAGE_IDX_W], ptr_r[`PAGE_IDX_W-1:0] + 4'h1};
          end
        end
        ST_RDATA: begin
          ack_drive_nxt = 1'b0; // R6
          armed_nxt = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (mack_ev && (state_r == ST_RDATA) && armed_r) begin
      armed_nxt = 1'b0;
      if (mack_lvl) begin
        state_nxt = ST_WAIT; // R16
        tx_mode_nxt = 1'b0; // R16
      end else begin
        ptr_nxt = ptr_r + 9'h001; // R11
        reload_nxt = 1'b1; // R11
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      ptr_r <= `PTR_RST;
      ack_drive_r <= 1'b0;
      tx_mode_r <= 1'b0;
      tx_byte_r <= `BYTE_RST;
      reload_r <= 1'b0;
      reload_d_r <= 1'b0;
      armed_r <= 1'b0;
      pmask_r <= `MASK_RST;
      pcnt_r <= 32'h0;
      frame_rst_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ptr_r <= ptr_nxt;
      ack_drive_r <= ack_drive_nxt;
      tx_mode_r <= tx_mode_nxt;
      tx_byte_r <= tx_byte_nxt;
      reload_r <= reload_nxt;
      reload_d_r <= reload_d_nxt;
      armed_r <= armed_nxt;
      pmask_r <= pmask_nxt;
      pcnt_r <= pcnt_nxt;
      frame_rst_r <= frame_rst_nxt;
    end
  end

  // Page buffer: data only, validity lives in the mask
  always_ff @(posedge ref_clk_i) begin
    if (pb_we) begin
      page_mem[ptr_r[`PAGE_IDX_W-1:0]] <= rx_byte;
    end
  end

  eeprom_cell_array #(
    .AW(`EE_ADDR_W),
    .DW(`EE_DATA_W)
  ) u_cells (
    .clk_i(ref_clk_i),
    .we_i(arr_we),
    .waddr_i({ptr_r[`EE_ADDR_W-1:`PAGE_IDX_W], prog_idx}),
    .wdata_i(page_mem[prog_idx]),
    .raddr_i(ptr_r),
    .rdata_o(rd_data)
  ); // R1

  i2c_bit_engine u_link (
    .scl_i(scl_i),
    .rst_i(rst_i),
    .frame_rst_i(link_rst),
    .sda_i(sda_i),
    .ack_drive_i(ack_drive_r),
    .tx_mode_i(tx_mode_r),
    .tx_byte_i(tx_byte_r),
    .rx_byte_o(rx_byte),
    .byte_tgl_o(byte_tgl),
    .mack_tgl_o(mack_tgl),
    .mack_o(mack_lvl),
    .sda_oe_o(sda_oe_o)
  ); // R8

  // Open drain: only ever a low level behind the enable
  assign sda_o = 1'b0; // R9
  assign prog_busy_o = (state_r == ST_PROG);

endmodule // i2c_eeprom_slave_upper_guard

`default_nettype wire

//--- tb/i2c_eeprom_slave_upper_guard_properties.sv
`timescale 1ns/1ps
`default_nettype none

module ee_guard_checker #(
  parameter int unsigned PROG_CYCLES = 64
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  // Status
  input wire logic prog_busy_o
);
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;

  always_comb begin
    busy_cnt_nxt = prog_busy_o ? busy_cnt_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) busy_cnt_r <= 32'h0;
    else busy_cnt_r <= busy_cnt_nxt;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_busy_rise;
    !prog_busy_o ##1 prog_busy_o;
  endsequence
  sequence s_scl_high;
    scl_i ##1 scl_i;
  endsequence

  property p_sda_o_zero;
    sda_o == 1'b0;
  endproperty
  property p_oe_on_scl_low;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  property p_oe_hold_high;
    s_scl_high |-> $stable(sda_oe_o);
  endproperty
  property p_oe_stands;
    $rose(sda_oe_o) |-> sda_oe_o [*8];
  endproperty
  property p_busy_quiet;
    s_busy_rise |-> !sda_oe_o [*8];
  endproperty
  property p_busy_idle_bus;
    s_busy_rise |-> scl_i && sda_i;
  endproperty
  // Window of one cycle for the stop detect jitter
  property p_busy_len;
    $fell(prog_busy_o) |-> busy_cnt_r >= PROG_CYCLES - 1 && busy_cnt_r <= PROG_CYCLES + 1;
  endproperty
  property p_reset_quiet;
    $fell(rst_i) |-> !sda_oe_o && !prog_busy_o;
  endproperty
  // Ack polling must see no-ack for the whole cycle
  property p_busy_no_pull;
    prog_busy_o |-> !sda_oe_o;
  endproperty

  a_sda_o_zero: assert property (p_sda_o_zero) else $error("sda value not low");
  a_oe_on_scl_low: assert property (p_oe_on_scl_low) else $error("pull moved, scl high");
  a_oe_hold_high: assert property (p_oe_hold_high) else $error("pull moved in high");
  a_oe_stands: assert property (p_oe_stands) else $error("pull too short");
  a_busy_quiet: assert property (p_busy_quiet) else $error("pull while busy");
  a_busy_idle_bus: assert property (p_busy_idle_bus) else $error("busy not after stop");
  a_busy_len: assert property (p_busy_len) else $error("program length wrong");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active at reset");
  a_busy_no_pull: assert property (p_busy_no_pull) else $error("ack given while busy");
endmodule // ee_guard_checker

bind i2c_eeprom_slave_upper_guard ee_guard_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .prog_busy_o(prog_busy_o)
);

`default_nettype wire

//--- tb/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_master_model (
  // Link
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  localparam int TQ = 160;

  // Clock idles high between frames
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic start();
    sda_pull_o = 1'b0;
    #TQ scl_o = 1'b1;
    #(2*TQ) sda_pull_o = 1'b1;
    #(2*TQ) scl_o = 1'b0;
    #TQ;
  endtask

  task automatic stop();
    sda_pull_o = 1'b1;
    #TQ scl_o = 1'b1;
    #(2*TQ) sda_pull_o = 1'b0;
    #(2*TQ);
  endtask

  // Sample late in the high phase, pull only changes in the low phase
  task automatic bit_slot(input logic b, output logic s);
    sda_pull_o = !b;
    #TQ scl_o = 1'b1;
    #(2*TQ) s = sda_i;
    scl_o = 1'b0;
    #TQ;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = !s;
  endtask

  task automatic rbyte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(!more, s);
  endtask
endmodule // i2c_master_model

`default_nettype wire

//--- tb/i2c_eeprom_slave_upper_guard_tb.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_eeprom_slave_upper_guard_tb;
  localparam int unsigned PROG = 400;
  localparam logic [3:0] ID = 4'h9; // Arbitrary value
  logic clk, rst, scl, sda, sda_out, oe, s_lo, s_hi, guard, busy, pull;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  assign sda = !((oe && !sda_out) || pull);

  i2c_eeprom_slave_upper_guard #(.DEVICE_TYPE_ID(ID), .PROG_CYCLES(PROG)) u_dut (
    .ref_clk_i(clk),
    .rst_i(rst),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_out),
    .sda_oe_o(oe),
    .chip_addr_strap_low_i(s_lo),
    .chip_addr_strap_high_i(s_hi),
    .upper_half_write_guard_i(guard),
    .prog_busy_o(busy)
  );

  i2c_master_model u_m (.sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Generous ceiling, a normal run needs about 18000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      $display("MISMATCH %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic sel(input logic [3:0] id, input logic [1:0] st, input logic a8, rw, exp);
    logic a;
    u_m.start();
    u_m.wbyte({id, st, a8, rw}, a);
    chk(a === exp, "select ack");
  endtask

  task automatic prog_wait();
    int c;
    c = 0;
    chk(busy === 1'b1, "busy after stop");
    sel(ID, 2'b01, 1'b0, 1'b0, 1'b0);
    u_m.stop();
    while (busy === 1'b1 && c < 1000) begin
      @(posedge clk);
      #2;
      c++;
    end
    chk(busy === 1'b0, "busy ends");
    repeat (4) @(posedge clk);
  endtask

  task automatic wr(input logic [8:0] ad, input int n, input logic [7:0] d0, input logic exp);
    logic a;
    sel(ID, 2'b01, ad[8], 1'b0, 1'b1);
    u_m.wbyte(ad[7:0], a);
    chk(a === 1'b1, "address ack");
    for (int i = 0; i < n; i++) begin
      u_m.wbyte(d0 + 8'(i), a);
      chk(a === exp, "data ack");
    end
    u_m.stop();
    if (exp) prog_wait();
  endtask

  task automatic rd(input logic [8:0] ad, input int n, input logic [7:0] d0);
    logic a;
    logic [7:0] b;
    sel(ID, 2'b01, ad[8], 1'b0, 1'b1);
    u_m.wbyte(ad[7:0], a);
    chk(a === 1'b1, "read address ack");
    sel(ID, 2'b01, ad[8], 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      u_m.rbyte(i < n - 1, b);
      chk(b === d0 + 8'(i), "read data");
    end
    u_m.rbyte(1'b0, b);
    chk(b === 8'hFF, "line released after no-ack");
    u_m.stop();
  endtask

  task automatic t_byte();
    logic [7:0] b;
    wr(9'h010, 1, 8'h5A, 1'b1);
    rd(9'h010, 1, 8'h5A);
    // Current address read: kept pointer, no address byte
    sel(ID, 2'b01, 1'b0, 1'b1, 1'b1);
    u_m.rbyte(1'b0, b);
    chk(b === 8'h5A, "current address read");
    u_m.stop();
  endtask

  task automatic t_page();
    wr(9'h120, 16, 8'h30, 1'b1);
    rd(9'h120, 16, 8'h30);
  endtask

  task automatic t_guard();
    @(posedge clk);
    #2 guard = 1'b1;
    wr(9'h125, 2, 8'hC0, 1'b0);
    wr(9'h025, 1, 8'h77, 1'b1);
    rd(9'h125, 2, 8'h35);
    rd(9'h025, 1, 8'h77);
    @(posedge clk);
    #2 guard = 1'b0;
  endtask

  task automatic t_select();
    sel(~ID, 2'b01, 1'b0, 1'b0, 1'b0);
    u_m.stop();
    sel(ID, 2'b10, 1'b0, 1'b1, 1'b0);
    u_m.stop();
    sel(ID, 2'b00, 1'b0, 1'b0, 1'b0);
    u_m.stop();
  endtask

  initial begin
    rst = 1'b1;
    guard = 1'b0;
    s_lo = 1'b1;
    s_hi = 1'b0;
    repeat (4) @(posedge clk);
    #2 rst = 1'b0;
    repeat (8) @(posedge clk);
    t_select();
    t_byte();
    t_page();
    t_guard();
    wrap_up();
  end
endmodule // i2c_eeprom_slave_upper_guard_tb

`default_nettype wire
